/* File: pkg/kex_defines.svh */
// Named constants for the key exchange message handler: register offsets,
// reset values, flag bit positions and message byte positions.
// Assumes inclusion by bare name from the package and the design file.
`ifndef KEX_DEFINES_SVH
`define KEX_DEFINES_SVH

// ----------------------------------------------------------------------
// Register map (APB byte addresses)
// ----------------------------------------------------------------------
`define KEX_CFG_OFS        8'h00
`define KEX_STAT_OFS       8'h04
`define KEX_PEND_OFS       8'h08

// ----------------------------------------------------------------------
// Field length reset values, in bytes
// ----------------------------------------------------------------------
`define KEX_NONCE_LEN_RST  8'h08
`define KEX_AUTH_LEN_RST   8'h14
`define KEX_PUB_LEN_RST    8'h40

// ----------------------------------------------------------------------
// Request flag bits and the quick request flag mask
// ----------------------------------------------------------------------
`define KEX_FL_FIRST       3
`define KEX_FL_RENEW       2
`define KEX_FL_BUMP        1
`define KEX_FL_SLOT        0
`define KEX_QUICK_MASK     4'h3

// ----------------------------------------------------------------------
// Message byte positions and counts
// ----------------------------------------------------------------------
`define KEX_HDR_FLAGS_IDX  3'h4
`define KEX_HDR_LAST_IDX   3'h5
`define KEX_ID_LAST_IDX    8'h03
`define KEX_PUB_FIELDS     10'h003
`define KEX_ONE            8'h01

`endif

/* File: pkg/kex_pkg.sv */
// Types shared by the key exchange message handler.
// Assumes the defines header sits beside it on the include path.
`include "kex_defines.svh"

package kex_pkg;

    // Request parser and response builder states
    typedef enum logic [3:0] {
        KEX_S_HDR  = 4'h1,
        KEX_S_BODY = 4'h2,
        KEX_S_WAIT = 4'h4,
        KEX_S_EMIT = 4'h8
    } kex_state_type;

    // Response field being produced
    typedef enum logic [2:0] {
        KEX_F_ID    = 3'h0,
        KEX_F_FLAGS = 3'h1,
        KEX_F_CNT   = 3'h2,
        KEX_F_NONCE = 3'h3,
        KEX_F_AUTH  = 3'h4,
        KEX_F_PUB   = 3'h5
    } kex_field_type;

    // Secret sequence bit, counter sequence bit and duplicate counter
    typedef struct packed {
        logic       sec_seq;
        logic       cnt_seq;
        logic [7:0] cnt;
    } kex_secstate_type;

endpackage : kex_pkg

/* File: design/kex_handler.sv */
// Terminal-side handler for full and quick key exchange messages.
// Assumes request bytes and crypto results come from logic on mclk,
// the crypto engine answers fill_field/fill_index combinationally.
//
// How it works
// (R1) Link identifier is 32 zero bits, ignored
// (R2) Full request flags: first, renew, bump, slot
// (R3) Full request body: nonce, modulus, generator, X
// (R4) Field lengths come from sign-on registers
// (R5) Key goes to slot chosen by request
// (R6) Bump flag: counter plus one, toggle seq
// (R7) Renew: new secret, toggle seq, clear counter
// (R8) First exchange: controller ignores authenticator
// (R9) Changes pending until connect-acknowledge, then stored
// (R10) Full response: id, flags, counter, nonce, auth, Y
// (R11) Quick request: id, flags, reserved, nonce
// (R12) Quick response ends after authenticator
// (R13) Response reports counter, seq bits, secret used
// (R14) Controller flags duplicate on counter mismatch
// (R15) Full exchange derives from private y
// (R16) Quick exchange derives from stored secret
// (R17) Controller derives from private x
// (R18) Public value fields are 64 bytes by default
// (R19) Nonce fields are 8 bytes by default
//
// Local design decisions: the APB interface to the registers and the address map.
`timescale 1ns/100ps
`default_nettype none
`include "kex_defines.svh"

module kex_handler (
    input  wire logic                    mclk,          // 20 MHz clock
    input  wire logic                    srst,          // Sync reset
    input  wire logic                    psel,          // APB select
    input  wire logic                    penable,       // APB enable
    input  wire logic                    pwrite,        // APB write
    input  wire logic [7:0]              paddr,         // APB address
    input  wire logic [31:0]             pwdata,        // APB write data
    output logic      [31:0]             prdata,        // APB read data
    output logic                         pready,        // APB ready
    output logic                         pslverr,       // APB error
    input  wire logic                    rx_valid,      // Request byte valid
    input  wire logic [7:0]              rx_data,       // Request byte
    input  wire logic                    rx_quick,      // Quick request
    output logic                         rx_ready,      // Request accept
    output logic                         tx_valid,      // Response valid
    output logic      [7:0]              tx_data,       // Response byte
    output logic                         tx_last,       // Last byte
    input  wire logic                    tx_ready,      // Response accept
    output kex_pkg::kex_field_type       fill_field,    // Field wanted
    output logic      [7:0]              fill_index,    // Byte in field
    input  wire logic [7:0]              fill_data,     // Crypto byte
    output logic                         derive_start,  // Start derive
    output logic                         derive_full,   // Full exchange
    output logic                         derive_renew,  // Make new secret
    input  wire logic                    derive_done,   // Derive finished
    output logic                         key_apply,     // Load session key
    output logic                         key_slot,      // Target slot
    input  wire logic                    connect_ack,   // Connect ack seen
    output logic                         nv_write,      // Store pulse
    output kex_pkg::kex_secstate_type    nv_state       // Committed state
);

    // ------------------------------------------------------------------
    // APB register file
    // ------------------------------------------------------------------
    logic [7:0]  nonce_len;
    logic [7:0]  auth_len;
    logic [7:0]  pub_len;
    logic [7:0]  next_nonce_len;
    logic [7:0]  next_auth_len;
    logic [7:0]  next_pub_len;
    logic [31:0] next_prdata;
    logic        next_pready;
    logic        next_pslverr;
    kex_pkg::kex_state_type    state;
    kex_pkg::kex_secstate_type pend;
    logic                      pend_valid;

    // One wait state per access; a zero length is refused to keep the
    // builder from running a field with no bytes
    always_comb begin
        next_nonce_len = nonce_len;
        next_auth_len  = auth_len;
        next_pub_len   = pub_len;
        next_prdata    = prdata;
        next_pready    = 1'b0;
        next_pslverr   = 1'b0;
        if (psel && penable && !pready) begin
            next_pready = 1'b1;
            case (paddr)
                `KEX_CFG_OFS: begin
                    if (pwrite) begin
                        if (pwdata[7:0] != 8'h00) begin
                            next_nonce_len = pwdata[7:0];      // R4
                        end
                        if (pwdata[15:8] != 8'h00) begin
                            next_auth_len = pwdata[15:8];      // R4
                        end
                        if (pwdata[23:16] != 8'h00) begin
                            next_pub_len = pwdata[23:16];      // R4
                        end
                    end
                    next_prdata = {8'h00, pub_len, auth_len, nonce_len};
                end
                `KEX_STAT_OFS: begin
                    next_prdata = {20'h00000, (state != kex_pkg::KEX_S_HDR),
                                   pend_valid, nv_state};
                end
                `KEX_PEND_OFS: begin
                    next_prdata = {22'h000000, pend};
                end
                default: begin
                    next_pslverr = 1'b1;
                    next_prdata  = 32'h00000000;
                end
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            nonce_len <= `KEX_NONCE_LEN_RST;                   // R19
            auth_len  <= `KEX_AUTH_LEN_RST;
            pub_len   <= `KEX_PUB_LEN_RST;                     // R18
            prdata    <= 32'h00000000;
            pready    <= 1'b0;
            pslverr   <= 1'b0;
        end else begin
            nonce_len <= next_nonce_len;
            auth_len  <= next_auth_len;
            pub_len   <= next_pub_len;
            prdata    <= next_prdata;
            pready    <= next_pready;
            pslverr   <= next_pslverr;
        end
    end

    // ------------------------------------------------------------------
    // Request parser and response builder
    // ------------------------------------------------------------------
    kex_pkg::kex_state_type next_state;
    kex_pkg::kex_field_type tx_field;
    kex_pkg::kex_field_type next_tx_field;
    kex_pkg::kex_field_type next_fill_field;
    logic [2:0]  hdr_idx;
    logic [2:0]  next_hdr_idx;
    logic [9:0]  remain;
    logic [9:0]  next_remain;
    logic [3:0]  req_flags;
    logic [3:0]  next_req_flags;
    logic        req_quick;
    logic        next_req_quick;
    logic [7:0]  next_fill_index;
    logic        next_rx_ready;
    logic        next_tx_valid;
    logic [7:0]  next_tx_data;
    logic        next_tx_last;
    logic        next_derive_start;
    logic        next_derive_full;
    logic        next_derive_renew;
    logic        next_key_apply;
    logic        next_key_slot;
    logic        rx_fire;
    logic [7:0]  field_last;
    logic        msg_end;

    assign rx_fire = rx_valid && rx_ready;

    // Response flags and counter bytes are built from the pending state, which by then
    // holds the counter and sequence bits this exchange leaves behind
    always_comb begin
        next_state        = state;
        next_hdr_idx      = hdr_idx;
        next_remain       = remain;
        next_req_flags    = req_flags;
        next_req_quick    = req_quick;
        next_fill_field   = fill_field;
        next_fill_index   = fill_index;
        next_tx_valid     = tx_valid;
        next_tx_data      = tx_data;
        next_tx_last      = tx_last;
        next_tx_field     = tx_field;
        next_derive_start = 1'b0;
        next_derive_full  = derive_full;
        next_derive_renew = derive_renew;
        next_key_apply    = 1'b0;
        next_key_slot     = key_slot;
        field_last        = 8'h00;
        msg_end           = 1'b0;
        if (tx_valid && tx_ready) begin
            next_tx_valid = 1'b0;
            next_tx_last  = 1'b0;
        end
        case (state)
            kex_pkg::KEX_S_HDR: begin
                if (rx_fire) begin
                    next_hdr_idx = hdr_idx + 3'h1;             // R1
                    if (hdr_idx == `KEX_HDR_FLAGS_IDX) begin
                        next_req_quick = rx_quick;
                        next_req_flags = rx_quick ?            // R11
                            (rx_data[3:0] & `KEX_QUICK_MASK) :
                            rx_data[3:0];                      // R2
                    end
                    if (hdr_idx == `KEX_HDR_LAST_IDX) begin
                        next_hdr_idx = 3'h0;
                        next_state   = kex_pkg::KEX_S_BODY;
                        next_remain  = {2'h0, nonce_len} +     // R3
                            (req_quick ? 10'h000 :
                             10'(pub_len) * `KEX_PUB_FIELDS);
                    end
                end
            end
            kex_pkg::KEX_S_BODY: begin
                if (rx_fire) begin
                    next_remain = remain - 10'h001;
                    if (remain == 10'h001) begin
                        next_state        = kex_pkg::KEX_S_WAIT;
                        next_derive_start = 1'b1;
                        next_derive_full  = !req_quick;        // R15 R16
                        next_derive_renew = !req_quick &&
                                            req_flags[`KEX_FL_RENEW];
                    end
                end
            end
            kex_pkg::KEX_S_WAIT: begin
                if (derive_done && !derive_start) begin
                    next_state      = kex_pkg::KEX_S_EMIT;
                    next_key_apply  = 1'b1;
                    next_key_slot   = req_flags[`KEX_FL_SLOT];  // R5
                    next_fill_field = kex_pkg::KEX_F_ID;
                    next_fill_index = 8'h00;
                end
            end
            kex_pkg::KEX_S_EMIT: begin
                if (!tx_valid || tx_ready) begin
                    next_tx_valid = 1'b1;
                    next_tx_field = fill_field;
                    case (fill_field)
                        kex_pkg::KEX_F_ID: begin
                            next_tx_data = 8'h00;              // R1
                            field_last   = `KEX_ID_LAST_IDX;
                        end
                        kex_pkg::KEX_F_FLAGS: begin
                            next_tx_data = {6'h00, pend.sec_seq,
                                            pend.cnt_seq};     // R10 R13
                        end
                        kex_pkg::KEX_F_CNT: begin
                            next_tx_data = pend.cnt;           // R13
                        end
                        kex_pkg::KEX_F_NONCE: begin
                            next_tx_data = fill_data;
                            field_last   = nonce_len - `KEX_ONE;
                        end
                        kex_pkg::KEX_F_AUTH: begin
                            next_tx_data = fill_data;
                            field_last   = auth_len - `KEX_ONE;
                            msg_end      = req_quick;          // R12
                        end
                        kex_pkg::KEX_F_PUB: begin
                            next_tx_data = fill_data;          // R10
                            field_last   = pub_len - `KEX_ONE;
                            msg_end      = 1'b1;
                        end
                        default: begin
                            next_tx_data = 8'h00;
                        end
                    endcase
                    if (fill_index == field_last) begin
                        next_fill_index = 8'h00;
                        next_fill_field =
                            kex_pkg::kex_field_type'(fill_field + 3'h1);
                        if (msg_end) begin
                            next_tx_last    = 1'b1;
                            next_state      = kex_pkg::KEX_S_HDR;
                            next_fill_field = kex_pkg::KEX_F_ID;
                        end
                    end else begin
                        next_fill_index = fill_index + `KEX_ONE;
                    end
                end
            end
            default: begin
                next_state = kex_pkg::KEX_S_HDR;
            end
        endcase
        next_rx_ready = (next_state == kex_pkg::KEX_S_HDR) ||
                        (next_state == kex_pkg::KEX_S_BODY);
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            state        <= kex_pkg::KEX_S_HDR;
            hdr_idx      <= 3'h0;
            remain       <= 10'h000;
            req_flags    <= 4'h0;
            req_quick    <= 1'b0;
            fill_field   <= kex_pkg::KEX_F_ID;
            fill_index   <= 8'h00;
            rx_ready     <= 1'b1;
            tx_valid     <= 1'b0;
            tx_data      <= 8'h00;
            tx_last      <= 1'b0;
            tx_field     <= kex_pkg::KEX_F_ID;
            derive_start <= 1'b0;
            derive_full  <= 1'b0;
            derive_renew <= 1'b0;
            key_apply    <= 1'b0;
            key_slot     <= 1'b0;
        end else begin
            state        <= next_state;
            hdr_idx      <= next_hdr_idx;
            remain       <= next_remain;
            req_flags    <= next_req_flags;
            req_quick    <= next_req_quick;
            fill_field   <= next_fill_field;
            fill_index   <= next_fill_index;
            rx_ready     <= next_rx_ready;
            tx_valid     <= next_tx_valid;
            tx_data      <= next_tx_data;
            tx_last      <= next_tx_last;
            tx_field     <= next_tx_field;
            derive_start <= next_derive_start;
            derive_full  <= next_derive_full;
            derive_renew <= next_derive_renew;
            key_apply    <= next_key_apply;
            key_slot     <= next_key_slot;
        end
    end

    // ------------------------------------------------------------------
    // Secret and duplicate counter state: committed and pending
    // ------------------------------------------------------------------
    kex_pkg::kex_secstate_type next_pend;
    kex_pkg::kex_secstate_type next_nv_state;
    kex_pkg::kex_secstate_type base;
    logic                      next_pend_valid;
    logic                      next_nv_write;
    logic                      commit;

    assign commit = connect_ack && pend_valid;

    // A newer exchange replaces stale pending work; its pending set
    // builds on a commit landing in the same cycle, which still stores
    always_comb begin
        next_pend       = pend;
        next_pend_valid = pend_valid;
        next_nv_state   = nv_state;
        next_nv_write   = 1'b0;
        base            = commit ? pend : nv_state;
        if (commit) begin
            next_nv_state   = pend;                            // R9
            next_nv_write   = 1'b1;
            next_pend_valid = 1'b0;
        end
        if (derive_start) begin
            next_pend = base;
            if (derive_renew) begin
                next_pend.sec_seq = !base.sec_seq;             // R7
                next_pend.cnt     = 8'h00;
                next_pend.cnt_seq = 1'b0;
            end
            if (req_flags[`KEX_FL_BUMP]) begin
                next_pend.cnt     = next_pend.cnt + `KEX_ONE;  // R6
                next_pend.cnt_seq = !next_pend.cnt_seq;
            end
            next_pend_valid = 1'b1;                            // R9
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            pend       <= '0;
            pend_valid <= 1'b0;
            nv_state   <= '0;
            nv_write   <= 1'b0;
        end else begin
            pend       <= next_pend;
            pend_valid <= next_pend_valid;
            nv_state   <= next_nv_state;
            nv_write   <= next_nv_write;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);

    sequence s_commit;
        connect_ack && pend_valid;
    endsequence

    sequence s_store;
        nv_write ##1 !nv_write;
    endsequence

    a_id_zero: assert property (                                 // R1
        tx_valid && tx_field == kex_pkg::KEX_F_ID |-> tx_data == 8'h00)
        else $error("link identifier byte not zero");
    a_flags_layout: assert property (                            // R10
        tx_valid && tx_field == kex_pkg::KEX_F_FLAGS |->
        tx_data == {6'h00, pend.sec_seq, pend.cnt_seq})
        else $error("response flags byte wrong");
    a_cnt_report: assert property (                              // R13
        tx_valid && tx_field == kex_pkg::KEX_F_CNT |-> tx_data == pend.cnt)
        else $error("reported counter differs from state");
    a_quick_no_pub: assert property (                            // R12
        tx_valid && req_quick |-> tx_field != kex_pkg::KEX_F_PUB)
        else $error("quick response carries public value");
    a_bump_wrap: assert property (                               // R6
        derive_start && req_flags[`KEX_FL_BUMP] && !derive_renew
        && !connect_ack |=>
        pend.cnt == 8'($past(nv_state.cnt) + 8'h01) &&
        pend.cnt_seq != $past(nv_state.cnt_seq))
        else $error("counter bump wrong");
    a_renew_reset: assert property (                             // R7
        derive_start && derive_renew && !connect_ack |=>
        pend.cnt == {7'h00, $past(req_flags[`KEX_FL_BUMP])} &&
        pend.cnt_seq == $past(req_flags[`KEX_FL_BUMP]) &&
        pend.sec_seq != $past(nv_state.sec_seq))
        else $error("secret renewal wrong");
    a_commit_only: assert property (                             // R9
        nv_state != $past(nv_state) |-> $past(connect_ack && pend_valid))
        else $error("committed state changed without ack");
    a_store_pulse: assert property (                             // R9
        s_commit |=> s_store)
        else $error("store pulse missing after commit");
    a_key_slot: assert property (                                // R5
        key_apply |-> key_slot == req_flags[`KEX_FL_SLOT] &&
        $past(state == kex_pkg::KEX_S_WAIT))
        else $error("key slot does not follow request");
    a_derive_mode: assert property (                             // R15 R16
        derive_start |-> derive_full == !req_quick &&
        (!req_quick || !derive_renew))
        else $error("derive mode wrong for exchange type");

endmodule : kex_handler

`default_nettype wire

/* File: sim/kex_crypto_model.sv */
// Crypto engine stand-in for the key exchange handler bench.
// Assumes the handler drives fill_field and fill_index on mclk.
`timescale 1ns/100ps
`default_nettype none
module kex_crypto_model (
    input  wire logic                   mclk,         // Clock
    input  wire logic                   srst,         // Sync reset
    input  wire logic                   derive_start, // Derive request
    input  wire kex_pkg::kex_field_type fill_field,   // Field wanted
    input  wire logic [7:0]             fill_index,   // Byte in field
    output logic      [7:0]             fill_data,    // Crypto byte
    output logic                        derive_done   // Derive finished
);
    logic [2:0] dly;
    // Pattern names field and index, so byte order shows at the output
    assign fill_data = {fill_index[4:0], fill_field};
    // Late answer: a real engine never replies at once
    always_ff @(posedge mclk) begin
        dly <= srst ? 3'h0 : {dly[1:0], derive_start};
    end
    assign derive_done = dly[2];
endmodule : kex_crypto_model
`default_nettype wire

/* File: sim/tb_kex_handler.sv */
// Self-checking bench for the key exchange message handler.
// Assumes the crypto model answers fill requests and derive pulses.
`timescale 1ns/100ps
`default_nettype none
module tb_kex_handler;
    logic mclk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 8'h00, rx_data = 8'h00, fill_data;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, err, rx_valid = 0, rx_quick = 0, rx_ready;
    logic tx_valid, tx_last, tx_ready = 1, derive_start, derive_full;
    logic derive_renew, derive_done, key_apply, key_slot, nv_write;
    logic connect_ack = 0, ks = 0, df = 0, dr = 0;
    logic [7:0] tx_data, fill_index;
    kex_pkg::kex_field_type fill_field;
    kex_pkg::kex_secstate_type nv_state;
    int fail_count = 0, n_checks = 0, nvc = 0;
    kex_handler kex_handler_i (
        .mclk, .srst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .rx_valid, .rx_data, .rx_quick, .rx_ready,
        .tx_valid, .tx_data, .tx_last, .tx_ready, .fill_field, .fill_index,
        .fill_data, .derive_start, .derive_full, .derive_renew,
        .derive_done, .key_apply, .key_slot, .connect_ack, .nv_write,
        .nv_state
    );
    kex_crypto_model kex_crypto_model_i (
        .mclk, .srst, .derive_start, .fill_field, .fill_index, .fill_data,
        .derive_done
    );
    initial forever #25 mclk = ~mclk;
    // Monitor for single-cycle pulses the tasks would otherwise miss
    always @(posedge mclk) begin
        if (key_apply === 1) ks <= key_slot;
        if (derive_start === 1) {df, dr} <= {derive_full, derive_renew};
        if (nv_write === 1) nvc <= nvc + 1;
    end
    task results;
        if (fail_count == 0 && n_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : results
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask : chk
    // APB master: hold request until pready sampled high
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge mclk);
        penable <= 1;
        do @(posedge mclk); while (pready !== 1);
        {rd, err} = {prdata, pslverr};
        {psel, penable} <= 2'b00;
    endtask : apb
    task send(input logic [7:0] b, input logic q);
        @(posedge mclk);
        {rx_valid, rx_data, rx_quick} <= {1'b1, b, q};
        do @(posedge mclk); while (rx_ready !== 1);
        rx_valid <= 0;
    endtask : send
    // Request out, then response in with field order checked
    task xchg(input logic [7:0] fl, input logic q, input logic [7:0] xf,
              input logic [7:0] xc);
        logic [7:0] e;
        int nb;
        nb = q ? 10 : 11;
        for (int i = 0; i < 6; i++) send(i == 4 ? fl : 8'h00, q);
        for (int i = 0; i < (q ? 2 : 5); i++) send(8'h5A, q);
        for (int k = 0; k < nb; k++) begin
            do @(posedge mclk); while (tx_valid !== 1);
            e = k < 4 ? 8'h00 : k == 4 ? xf : k == 5 ? xc :
                k < 8 ? {k[4:0] - 5'h06, 3'h3} :
                k < 10 ? {k[4:0] - 5'h08, 3'h4} : 8'h05;
            chk(tx_data, e);
            chk(tx_last, k == nb - 1);
        end
        chk({df, dr}, {~q, fl[2] & ~q});
    endtask : xchg
    task commit(input logic [9:0] exp, input int prior);
        chk(nvc, prior);
        @(posedge mclk);
        connect_ack <= 1;
        @(posedge mclk);
        connect_ack <= 0;
        repeat (3) @(posedge mclk);
        chk(nvc, prior + 1);
        chk(nv_state, exp);
    endtask : commit
    initial begin
        #200000;
        fail_count++;
        results;
    end
    initial begin
        repeat (8) @(posedge mclk);
        srst <= 0;
        apb(0, 8'h00, 0);
        chk(rd, 32'h0040_1408);
        apb(1, 8'h00, 32'h0001_0202);
        apb(0, 8'h00, 0);
        chk(rd, 32'h0001_0202);
        apb(0, 8'h0C, 0);
        chk(err, 1);
        chk(rd, 32'h0);
        xchg(8'h03, 1, 8'h01, 8'h01);
        chk(ks, 1);
        chk(nv_state, 0);
        commit(10'h101, 0);
        xchg(8'h0E, 0, 8'h03, 8'h01);
        chk(ks, 0);
        commit(10'h301, 1);
        apb(0, 8'h04, 0);
        chk(rd, 32'h0000_0301);
        results;
    end
endmodule : tb_kex_handler
`default_nettype wire
